// ===== src/vpic_cfg.svh
// Interrupt controller constants: offsets, fields, resets, vectors.
// Definitions only; include where needed.
`ifndef VPIC_CFG_SVH
`define VPIC_CFG_SVH

// Source counts
`define VPIC_NSRC          24
`define VPIC_NPERIPH_A     8
`define VPIC_NPERIPH_B     4
`define VPIC_NSHARED       8
`define VPIC_NDUAL         4

// Rank bases of each source group
`define VPIC_RANK_PERIPH_A 0
`define VPIC_RANK_SHARED   8
`define VPIC_RANK_PERIPH_B 16
`define VPIC_RANK_DUAL     20
`define VPIC_RANK_TIMER3   16

// Fixed vector addresses
`define VPIC_VEC_RESET     16'h0002
`define VPIC_VEC_WDT       16'h0004
`define VPIC_VEC_TRAP      16'h0006
`define VPIC_VEC_SRC_BASE  16'h0008

// Priority level codes
`define VPIC_LVL2          2'h2
`define VPIC_LVL3          2'h3
`define VPIC_LVL_RST       2'h1

// Register byte offsets
`define VPIC_OFS_CTRL      8'h00
`define VPIC_OFS_PEND      8'h04
`define VPIC_OFS_ENAB      8'h08
`define VPIC_OFS_PRIO_LO   8'h0C
`define VPIC_OFS_PRIO_HI   8'h10
`define VPIC_OFS_PINCFG    8'h14
`define VPIC_OFS_VECT      8'h18
`define VPIC_OFS_STAT      8'h1C
`define VPIC_OFS_MASK      8'h20

// Control register fields
`define VPIC_CTRL_MIE      0
`define VPIC_CTRL_WDTI     1

// Event status / mask fields
`define VPIC_STAT_ACK      0
`define VPIC_STAT_WDT      1
`define VPIC_STAT_TRAP     2

// Reset values
`define VPIC_RST_PEND      24'h00_0000
`define VPIC_RST_ENAB      24'h00_0000
`define VPIC_RST_PINCFG    16'h0000
`define VPIC_RST_STAT      3'h0
`define VPIC_RST_MASK      3'h0
`define VPIC_RST_WORD      32'h0000_0000

`endif

// ===== src/vpic_pkg.sv
// Types shared by the interrupt controller files.
// Assumes the constants header is included by each user.
package vpic_pkg;

    // Kind of request presented to the core
    typedef enum logic [1:0] {
        VPIC_KIND_NONE,
        VPIC_KIND_TRAP,
        VPIC_KIND_WDT,
        VPIC_KIND_SRC
    } vpic_kind_t;

    typedef logic [23:0] vpic_src_t;
    typedef logic [1:0]  vpic_lvl_t;

endpackage

// ===== src/vpic_edge_detect.sv
// Edge detector of the twelve pin sources.
// Pins synchronous to core_clk; outputs are flopped one-cycle pulses.
`timescale 1ns/100ps
`include "vpic_cfg.svh"

module vpic_edge_detect (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Pins
    input  wire logic [7:0] port_a_pin,
    input  wire logic [7:0] port_d_pin,
    input  wire logic [3:0] port_c_pin,
    // Configuration
    input  wire logic [7:0] shared_sel_d,
    input  wire logic [7:0] shared_rise,
    // Edge pulses
    output logic      [7:0] shared_edge,
    output logic      [3:0] dual_edge
);

    logic [7:0] a_prev_r;
    logic [7:0] d_prev_r;
    logic [3:0] c_prev_r;
    logic [7:0] shared_nxt;
    logic [3:0] dual_nxt;

    // Per-bit decode; both ports keep history, so a select
    // change alone shows no false edge
    genvar g;
    generate
        for (g = 0; g < `VPIC_NSHARED; g++) begin : g_shared
            logic cur_b;
            logic prv_b;
            assign cur_b = shared_sel_d[g] ? port_d_pin[g] : port_a_pin[g];
            assign prv_b = shared_sel_d[g] ? d_prev_r[g] : a_prev_r[g];
            assign shared_nxt[g] = shared_rise[g] ? (cur_b & ~prv_b)
                                                  : (~cur_b & prv_b); // see R02
        end
        for (g = 0; g < `VPIC_NDUAL; g++) begin : g_dual
            assign dual_nxt[g] = port_c_pin[g] ^ c_prev_r[g]; // see R02
        end
    endgenerate

    // History and pulse registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_prev_r    <= 8'h00;
            d_prev_r    <= 8'h00;
            c_prev_r    <= 4'h0;
            shared_edge <= 8'h00;
            dual_edge   <= 4'h0;
        end else begin
            a_prev_r    <= port_a_pin;
            d_prev_r    <= port_d_pin;
            c_prev_r    <= port_c_pin;
            shared_edge <= shared_nxt;
            dual_edge   <= dual_nxt;
        end
    end

endmodule

// ===== src/vpic_top.sv
// Interrupt controller: 24 ranked sources, three levels,
// Wishbone registers, vector hand-off to the core.
// Assumes one clock and one-cycle source pulses;
// the core acknowledges a vector with a one-cycle pulse.
//
// Behaviour
// R01: Twelve pin and twelve peripheral sources own 24 vectors.
// R02: Eight pin sources use a chosen edge, four use both.
// R03: Each source has one of three priority levels.
// R04: The watchdog may interrupt at 0004H instead of resetting.
// R05: A vector is two bytes, high byte at the even address.
// R06: Polled use reads pending bits and leaves the core alone.
// R07: Reset 0002H and trap 0006H rank on top, not maskable.
// R08: Peripherals rank timer 2 to converter at 0008H to 0016H.
// R09: Shared pin edges use 0018H to 0026H, bit 7 first.
// R10: Timer 3, second UART pair and DMA use 0028H to 002EH.
// R11: Port C bits 3 to 0 rank lowest at 0030H to 0036H.
// R12: An accepted request diverts the core to its routine.
// R13: Highest pending level wins; ties go by fixed order.
// R14: A master enable, set and cleared by listed events, gates vectors.
// R15: Level 3 beats 2 beats 1; fixed order only inside a level.
// R16: A source pulse sets a pending bit; ack or a 0 write clears it.
// R17: Writing 1 raises a pending bit; ack clears it.
`timescale 1ns/100ps
`include "vpic_cfg.svh"

module vpic_top #(
    parameter bit HAS_TIMER3 = 1'b1
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Peripheral request pulses
    input  wire logic [7:0]  periph_req_a,
    input  wire logic [3:0]  periph_req_b,
    input  wire logic        wdt_timeout,
    // Port pins
    input  wire logic [7:0]  port_a_pin,
    input  wire logic [7:0]  port_d_pin,
    input  wire logic [3:0]  port_c_pin,
    // Core instruction events
    input  wire logic        enable_int_instr,
    input  wire logic        disable_int_instr,
    input  wire logic        return_from_int_instr,
    input  wire logic        trap_instr,
    input  wire logic        illegal_instr_trap,
    input  wire logic        core_ack,
    // Core vector hand-off
    output logic             core_irq,
    output logic [15:0]      core_vec_msb_addr,
    output logic [15:0]      core_vec_lsb_addr,
    // System interrupt
    output logic             sys_irq
);

    // Register state
    vpic_pkg::vpic_src_t pend_r, pend_nxt;
    vpic_pkg::vpic_src_t enab_r, enab_nxt;
    logic [47:0]         prio_r, prio_nxt;
    logic [15:0]         pincfg_r, pincfg_nxt;
    logic                master_irq_enable_r, master_irq_enable_nxt;
    logic                wdt_irq_mode_r, wdt_irq_mode_nxt;
    logic                wdt_pend_r, wdt_pend_nxt;
    logic                trap_pend_r, trap_pend_nxt;
    logic [2:0]          stat_r, stat_nxt;
    logic [2:0]          mask_r, mask_nxt;
    // Presentation state
    vpic_pkg::vpic_kind_t kind_r, kind_nxt;
    logic [4:0]          src_r, src_nxt;
    logic                irq_nxt;
    logic [15:0]         vec_nxt;
    logic                sys_irq_nxt;
    // Bus state
    logic                ack_nxt;
    logic [31:0]         rdat_nxt;
    // Combinational helpers
    logic [7:0]          shared_edge;
    logic [3:0]          dual_edge;
    vpic_pkg::vpic_src_t src_ev;
    vpic_pkg::vpic_src_t req_live;
    vpic_pkg::vpic_src_t hit3, hit2, hit1, cand;
    logic [4:0]          win_idx;
    logic                win_any;
    logic [31:0]         bmask;
    logic                bus_req;
    logic                wr_go;
    logic                rd_go;

    // Pin edge detection for the twelve pin sources
    vpic_edge_detect u_edge (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .port_a_pin   (port_a_pin),
        .port_d_pin   (port_d_pin),
        .port_c_pin   (port_c_pin),
        .shared_sel_d (pincfg_r[15:8]),
        .shared_rise  (pincfg_r[7:0]),
        .shared_edge  (shared_edge),
        .dual_edge    (dual_edge)
    );

    // Gather events by rank: bit 0 is the highest fixed rank
    always_comb begin
        src_ev = '0;
        for (int i = 0; i < `VPIC_NPERIPH_A; i++) begin
            src_ev[`VPIC_RANK_PERIPH_A + i] = periph_req_a[7 - i]; // see R08
            src_ev[`VPIC_RANK_SHARED + i]   = shared_edge[7 - i];  // see R09
        end
        for (int i = 0; i < `VPIC_NPERIPH_B; i++) begin
            src_ev[`VPIC_RANK_PERIPH_B + i] = periph_req_b[3 - i]; // see R10
            src_ev[`VPIC_RANK_DUAL + i]     = dual_edge[3 - i];    // see R11
        end
        if (!HAS_TIMER3) begin
            src_ev[`VPIC_RANK_TIMER3] = 1'b0; // see R10
        end
    end

    // Per-source level split; an unused code 0 counts as level 1
    genvar g;
    generate
        for (g = 0; g < `VPIC_NSRC; g++) begin : g_lvl
            vpic_pkg::vpic_lvl_t lvl;
            assign lvl     = prio_r[2*g+1:2*g];
            assign hit3[g] = req_live[g] & (lvl == `VPIC_LVL3); // see R03
            assign hit2[g] = req_live[g] & (lvl == `VPIC_LVL2);
            assign hit1[g] = req_live[g] & (lvl != `VPIC_LVL3) & (lvl != `VPIC_LVL2);
        end
    endgenerate

    // Winner: highest level first, then highest fixed rank (lowest bit)
    always_comb begin
        req_live = pend_r & enab_r;
        if (|hit3) begin
            cand = hit3; // see R15
        end else if (|hit2) begin
            cand = hit2;
        end else begin
            cand = hit1;
        end
        win_any = |cand;
        win_idx = 5'h00;
        for (int i = `VPIC_NSRC - 1; i >= 0; i--) begin
            if (cand[i]) begin
                win_idx = 5'(i); // see R13
            end
        end
    end

    // Wishbone decode helpers
    always_comb begin
        bus_req = wb_cyc_i & wb_stb_i;
        wr_go   = bus_req & wb_we_i & wb_ack_o;  // write lands on the ack edge
        rd_go   = bus_req & ~wb_we_i & wb_ack_o;
        for (int b = 0; b < 4; b++) begin
            bmask[8*b +: 8] = {8{wb_sel_i[b]}};
        end
    end

    // Bus answer and read mux, latched with ack
    always_comb begin
        ack_nxt  = bus_req & ~wb_ack_o;
        rdat_nxt = wb_dat_o;
        if (bus_req & ~wb_ack_o & ~wb_we_i) begin
            if (wb_adr_i == `VPIC_OFS_CTRL) begin
                rdat_nxt = {30'h0000_0000, wdt_irq_mode_r, master_irq_enable_r};
            end else if (wb_adr_i == `VPIC_OFS_PEND) begin
                rdat_nxt = {8'h00, pend_r}; // see R06
            end else if (wb_adr_i == `VPIC_OFS_ENAB) begin
                rdat_nxt = {8'h00, enab_r};
            end else if (wb_adr_i == `VPIC_OFS_PRIO_LO) begin
                rdat_nxt = prio_r[31:0];
            end else if (wb_adr_i == `VPIC_OFS_PRIO_HI) begin
                rdat_nxt = {16'h0000, prio_r[47:32]};
            end else if (wb_adr_i == `VPIC_OFS_PINCFG) begin
                rdat_nxt = {16'h0000, pincfg_r};
            end else if (wb_adr_i == `VPIC_OFS_VECT) begin
                rdat_nxt = {11'h000, src_r, core_vec_msb_addr};
            end else if (wb_adr_i == `VPIC_OFS_STAT) begin
                rdat_nxt = {29'h0000_0000, stat_r};
            end else if (wb_adr_i == `VPIC_OFS_MASK) begin
                rdat_nxt = {29'h0000_0000, mask_r};
            end else begin
                rdat_nxt = `VPIC_RST_WORD; // unmapped reads zero
            end
        end
    end

    // Bus registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `VPIC_RST_WORD;
        end else begin
            wb_ack_o <= ack_nxt;
            wb_dat_o <= rdat_nxt;
        end
    end

    // Configuration registers, byte lanes honoured
    always_comb begin
        enab_nxt         = enab_r;
        prio_nxt         = prio_r;
        pincfg_nxt       = pincfg_r;
        mask_nxt         = mask_r;
        wdt_irq_mode_nxt = wdt_irq_mode_r;
        if (wr_go) begin
            if (wb_adr_i == `VPIC_OFS_CTRL) begin
                if (wb_sel_i[0]) begin
                    wdt_irq_mode_nxt = wb_dat_i[`VPIC_CTRL_WDTI]; // see R04
                end
            end else if (wb_adr_i == `VPIC_OFS_ENAB) begin
                enab_nxt = (enab_r & ~bmask[23:0]) | (wb_dat_i[23:0] & bmask[23:0]);
            end else if (wb_adr_i == `VPIC_OFS_PRIO_LO) begin
                prio_nxt[31:0] = (prio_r[31:0] & ~bmask) | (wb_dat_i & bmask); // see R03
            end else if (wb_adr_i == `VPIC_OFS_PRIO_HI) begin
                prio_nxt[47:32] = (prio_r[47:32] & ~bmask[15:0])
                                | (wb_dat_i[15:0] & bmask[15:0]);
            end else if (wb_adr_i == `VPIC_OFS_PINCFG) begin
                pincfg_nxt = (pincfg_r & ~bmask[15:0]) | (wb_dat_i[15:0] & bmask[15:0]);
            end else if (wb_adr_i == `VPIC_OFS_MASK) begin
                if (wb_sel_i[0]) begin
                    mask_nxt = wb_dat_i[2:0];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enab_r         <= `VPIC_RST_ENAB;
            prio_r         <= {`VPIC_NSRC{`VPIC_LVL_RST}};
            pincfg_r       <= `VPIC_RST_PINCFG;
            mask_r         <= `VPIC_RST_MASK;
            wdt_irq_mode_r <= 1'b0;
        end else begin
            enab_r         <= enab_nxt;
            prio_r         <= prio_nxt;
            pincfg_r       <= pincfg_nxt;
            mask_r         <= mask_nxt;
            wdt_irq_mode_r <= wdt_irq_mode_nxt;
        end
    end

    // Pending flags: clears first, then sets,
    // so an event in a clearing cycle survives
    always_comb begin
        pend_nxt      = pend_r;
        wdt_pend_nxt  = wdt_pend_r;
        trap_pend_nxt = trap_pend_r;
        if (core_ack) begin
            if (kind_r == vpic_pkg::VPIC_KIND_TRAP) begin
                trap_pend_nxt = 1'b0;
            end else if (kind_r == vpic_pkg::VPIC_KIND_WDT) begin
                wdt_pend_nxt = 1'b0;
            end else if (kind_r == vpic_pkg::VPIC_KIND_SRC) begin
                pend_nxt[src_r] = 1'b0; // see R16, R17
            end
        end
        if (wr_go && (wb_adr_i == `VPIC_OFS_PEND)) begin
            // Write 1 raises, write 0 drops, per byte lane
            pend_nxt = (pend_nxt & ~bmask[23:0]) | (wb_dat_i[23:0] & bmask[23:0]); // see R17
        end
        pend_nxt = pend_nxt | src_ev; // see R16, R01
        if (wdt_timeout & wdt_irq_mode_r) begin
            wdt_pend_nxt = 1'b1; // see R04
        end
        if (illegal_instr_trap) begin
            trap_pend_nxt = 1'b1; // see R07
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r      <= `VPIC_RST_PEND;
            wdt_pend_r  <= 1'b0;
            trap_pend_r <= 1'b0;
        end else begin
            pend_r      <= pend_nxt;
            wdt_pend_r  <= wdt_pend_nxt;
            trap_pend_r <= trap_pend_nxt;
        end
    end

    // Master enable; core-side clears beat core-side sets, a bus write wins
    always_comb begin
        master_irq_enable_nxt = master_irq_enable_r;
        if (enable_int_instr | return_from_int_instr) begin
            master_irq_enable_nxt = 1'b1; // see R14
        end
        if (disable_int_instr | core_ack | trap_instr | illegal_instr_trap) begin
            master_irq_enable_nxt = 1'b0; // see R14
        end
        if (wr_go && (wb_adr_i == `VPIC_OFS_CTRL) && wb_sel_i[0]) begin
            master_irq_enable_nxt = wb_dat_i[`VPIC_CTRL_MIE]; // see R14
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            master_irq_enable_r <= 1'b0; // see R14
        end else begin
            master_irq_enable_r <= master_irq_enable_nxt;
        end
    end

    // To the core: trap ignores the master enable,
    // the rest need it, so polled use leaves the core be
    always_comb begin
        kind_nxt = vpic_pkg::VPIC_KIND_NONE;
        src_nxt  = src_r;
        vec_nxt  = core_vec_msb_addr;
        if (trap_pend_r) begin
            kind_nxt = vpic_pkg::VPIC_KIND_TRAP;
            vec_nxt  = `VPIC_VEC_TRAP; // see R07
        end else if (master_irq_enable_r & wdt_pend_r) begin
            kind_nxt = vpic_pkg::VPIC_KIND_WDT;
            vec_nxt  = `VPIC_VEC_WDT; // see R04
        end else if (master_irq_enable_r & win_any) begin
            kind_nxt = vpic_pkg::VPIC_KIND_SRC;
            src_nxt  = win_idx;
            vec_nxt  = `VPIC_VEC_SRC_BASE + {10'h000, win_idx, 1'b0}; // see R08, R13
        end
        // Drop the line on the ack edge so one request is taken once
        irq_nxt = (kind_nxt != vpic_pkg::VPIC_KIND_NONE) & ~core_ack; // see R06, R12
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            kind_r            <= vpic_pkg::VPIC_KIND_NONE;
            src_r             <= 5'h00;
            core_irq          <= 1'b0;
            core_vec_msb_addr <= `VPIC_VEC_RESET; // see R07
            core_vec_lsb_addr <= `VPIC_VEC_RESET + 16'h0001;
        end else begin
            kind_r            <= irq_nxt ? kind_nxt : vpic_pkg::VPIC_KIND_NONE;
            src_r             <= src_nxt;
            core_irq          <= irq_nxt; // see R12
            core_vec_msb_addr <= vec_nxt;                // see R05
            core_vec_lsb_addr <= vec_nxt | 16'h0001;    // see R05
        end
    end

    // Event status: sticky, read clears only bits that were returned
    always_comb begin
        stat_nxt = stat_r;
        if (rd_go && (wb_adr_i == `VPIC_OFS_STAT)) begin
            stat_nxt = stat_r & ~wb_dat_o[2:0];
        end
        if (core_ack) begin
            stat_nxt[`VPIC_STAT_ACK] = 1'b1;
        end
        if (wdt_timeout & wdt_irq_mode_r) begin
            stat_nxt[`VPIC_STAT_WDT] = 1'b1;
        end
        if (illegal_instr_trap) begin
            stat_nxt[`VPIC_STAT_TRAP] = 1'b1;
        end
        sys_irq_nxt = |(stat_nxt & mask_r);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r  <= `VPIC_RST_STAT;
            sys_irq <= 1'b0;
        end else begin
            stat_r  <= stat_nxt;
            sys_irq <= sys_irq_nxt;
        end
    end

endmodule

// ===== verif/vpic_top_props.sv
// Port checker of the interrupt controller.
// Assumes the vpic_top port names; bound at the foot of this file.
`timescale 1ns/100ps
module vpic_top_props (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // Core side
    input wire logic        core_ack,
    input wire logic        illegal_instr_trap,
    input wire logic        core_irq,
    input wire logic [15:0] core_vec_msb_addr,
    input wire logic [15:0] core_vec_lsb_addr
);
    // One clock domain, one reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // One wait state, one-cycle ack
    AST_ACK_WAIT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    // Vector halves and range
    AST_VEC_PAIR: assert property (core_vec_lsb_addr == (core_vec_msb_addr | 16'h0001))
        else $error("low byte address not odd partner");
    AST_VEC_RANGE: assert property (core_irq |-> !core_vec_msb_addr[0] &&
        core_vec_msb_addr >= 16'h0004 && core_vec_msb_addr <= 16'h0036)
        else $error("presented vector out of table");
    // Hand-off holds until taken, then drops
    AST_VEC_HOLD: assert property (core_irq && !core_ack ##1 core_irq |-> $stable(core_vec_msb_addr))
        else $error("vector changed while presented");
    AST_IRQ_DROP: assert property (core_irq && core_ack |=> !core_irq)
        else $error("request kept after acknowledge");
    // Ack clears master enable; only a trap may follow
    AST_ACK_MASKS: assert property (core_ack |=> !core_irq ##1
        (!core_irq || core_vec_msb_addr == 16'h0006))
        else $error("source presented right after acknowledge");
    AST_TRAP_VEC: assert property (illegal_instr_trap && !core_irq |->
        ##[1:3] (core_irq && core_vec_msb_addr == 16'h0006))
        else $error("trap not presented");
    AST_RESET_VEC: assert property ($rose(rst_n) |-> core_vec_msb_addr == 16'h0002 && !core_irq)
        else $error("reset vector wrong");

    // Main scenarios reached
    cover property (core_ack && core_vec_msb_addr == 16'h0036);
    cover property (core_ack && core_vec_msb_addr == 16'h0004);
    cover property (core_ack && core_vec_msb_addr == 16'h0006);
endmodule

bind vpic_top vpic_top_props u_props (
    .core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .core_ack, .illegal_instr_trap,
    .core_irq, .core_vec_msb_addr, .core_vec_lsb_addr
);

// ===== verif/vpic_core_model.sv
// Behavioural processor core taking vectored interrupts.
// Assumes requests and vectors from vpic_top, one shared clock.
`timescale 1ns/100ps
module vpic_core_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Hand-off
    input  wire logic        core_irq,
    input  wire logic [15:0] core_vec_msb_addr,
    output logic             core_ack,
    output logic             return_from_int_instr,
    // Pacing and record
    input  int               ack_wait,
    output logic [15:0]      last_vec,
    output int               taken
);
    initial begin
        core_ack = 1'b0;
        return_from_int_instr = 1'b0;
        last_vec = 16'h0000;
        taken = 0;
    end

    // Take vector, run routine, return
    always begin
        @(posedge core_clk);
        if (rst_n && core_irq === 1'b1) begin
            repeat (ack_wait) @(posedge core_clk);
            core_ack <= 1'b1;
            last_vec <= core_vec_msb_addr;
            taken <= taken + 1;
            @(posedge core_clk);
            core_ack <= 1'b0;
            repeat (4) @(posedge core_clk);
            return_from_int_instr <= 1'b1;
            @(posedge core_clk);
            return_from_int_instr <= 1'b0;
        end
    end
endmodule

// ===== verif/vpic_top_bench.sv
// Self-checking bench of the interrupt controller.
// Assumes the core model answers hand-offs; four rarely used inputs tied.
`timescale 1ns/100ps
`include "vpic_cfg.svh"
module vpic_top_bench;
    logic        core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i, periph_req_a, port_a_pin;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0]  periph_req_b, port_c_pin;
    logic        wdt_timeout, enable_int_instr, illegal_instr_trap, core_ack, ret_instr;
    logic        core_irq, sys_irq;
    logic [15:0] vec_msb, last_vec;
    int          ack_wait, taken, num_errors, comparisons;

    vpic_top DUT (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .periph_req_a, .periph_req_b,
        .wdt_timeout, .port_a_pin, .port_d_pin(8'h00), .port_c_pin, .enable_int_instr,
        .disable_int_instr(1'b0), .return_from_int_instr(ret_instr), .trap_instr(1'b0),
        .illegal_instr_trap, .core_ack, .core_irq, .core_vec_msb_addr(vec_msb),
        .core_vec_lsb_addr(), .sys_irq);
    vpic_core_model u_core (.core_clk, .rst_n, .core_irq, .core_vec_msb_addr(vec_msb),
        .core_ack, .return_from_int_instr(ret_instr), .ack_wait, .last_vec, .taken);

    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Classic single access, held until ack; only the watchdog ends a wait
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge core_clk);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Wait for the core to take one vector
    task automatic serve(input logic [15:0] v);
        int t0;
        t0 = taken;
        while (taken == t0) @(posedge core_clk);
        check("taken vector", {16'h0000, last_vec}, {16'h0000, v});
    endtask

    task automatic t_reset;
        logic [7:0] ofs [6] = '{`VPIC_OFS_CTRL, `VPIC_OFS_PEND, `VPIC_OFS_ENAB,
            `VPIC_OFS_PINCFG, `VPIC_OFS_MASK, 8'h40};
        foreach (ofs[i]) begin
            wb(1'b0, ofs[i], 32'h0000_0000);
            check("reset word", rd, 32'h0000_0000);
        end
        wb(1'b0, `VPIC_OFS_PRIO_LO, 32'h0000_0000);
        check("reset levels", rd, 32'h5555_5555);
        check("reset vector", {16'h0000, vec_msb}, 32'h0000_0002);
    endtask

    // Polled use: pulses and pin edges only set pending bits
    task automatic t_poll;
        @(posedge core_clk);
        periph_req_a <= 8'h01;
        periph_req_b <= 4'h1;
        port_a_pin   <= 8'h10;
        port_c_pin   <= 4'h2;
        @(posedge core_clk);
        periph_req_a <= 8'h00;
        periph_req_b <= 4'h0;
        repeat (4) @(posedge core_clk);
        wb(1'b0, `VPIC_OFS_PEND, 32'h0000_0000);
        check("pending", rd, 32'h0048_0480);
        check("polled irq", {31'h0, core_irq}, 32'h0000_0000);
        wb(1'b1, `VPIC_OFS_PEND, 32'h0000_0000);
        port_c_pin <= 4'h0;
        repeat (4) @(posedge core_clk);
        wb(1'b0, `VPIC_OFS_PEND, 32'h0000_0000);
        check("falling dual edge", rd, 32'h0040_0000);
    endtask

    // All 24 pending at one level, served in fixed order
    task automatic t_order;
        ack_wait = 0;
        wb(1'b1, `VPIC_OFS_ENAB, 32'h00FF_FFFF);
        wb(1'b1, `VPIC_OFS_PEND, 32'h00FF_FFFF);
        @(posedge core_clk);
        enable_int_instr <= 1'b1;
        @(posedge core_clk);
        enable_int_instr <= 1'b0;
        for (int i = 0; i < 24; i++)
            serve(16'h0008 + 16'(2 * i));
    endtask

    // Level beats fixed order; slow core
    task automatic t_levels;
        ack_wait = 3;
        wb(1'b1, `VPIC_OFS_PRIO_LO, 32'h5655_5555);
        wb(1'b1, `VPIC_OFS_PRIO_HI, 32'h0000_D555);
        wb(1'b1, `VPIC_OFS_CTRL, 32'h0000_0001);
        wb(1'b1, `VPIC_OFS_PEND, 32'h0080_1001);
        serve(16'h0036);
        serve(16'h0020);
        serve(16'h0008);
    endtask

    // Watchdog and trap events, status and mask
    task automatic t_events;
        wb(1'b1, `VPIC_OFS_CTRL, 32'h0000_0003);
        @(posedge core_clk);
        wdt_timeout <= 1'b1;
        @(posedge core_clk);
        wdt_timeout <= 1'b0;
        serve(`VPIC_VEC_WDT);
        repeat (8) @(posedge core_clk);
        wb(1'b1, `VPIC_OFS_CTRL, 32'h0000_0000);
        @(posedge core_clk);
        illegal_instr_trap <= 1'b1;
        @(posedge core_clk);
        illegal_instr_trap <= 1'b0;
        serve(`VPIC_VEC_TRAP);
        check("masked line", {31'h0, sys_irq}, 32'h0000_0000);
        wb(1'b1, `VPIC_OFS_MASK, 32'h0000_0007);
        repeat (2) @(posedge core_clk);
        check("event line", {31'h0, sys_irq}, 32'h0000_0001);
        wb(1'b0, `VPIC_OFS_STAT, 32'h0000_0000);
        check("status", rd, 32'h0000_0007);
        repeat (2) @(posedge core_clk);
        check("line after read", {31'h0, sys_irq}, 32'h0000_0000);
    endtask

    // Main sequence
    initial begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wdt_timeout, enable_int_instr} = '0;
        {wb_adr_i, wb_dat_i, periph_req_a, periph_req_b, port_c_pin} = '0;
        illegal_instr_trap = 1'b0;
        port_a_pin = 8'h20;
        {ack_wait, num_errors, comparisons} = '0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_poll;
        t_order;
        t_levels;
        t_events;
        stop_test;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        stop_test;
    end
endmodule
